/* File: dv/hbt_host_model.sv */
// host bus model: drives strobes and waits for the device answer
`timescale 1ns/100ps
`default_nettype none

module hbt_host_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_style,
  input  wire logic        i_wait_n,
  input  wire logic        i_wait_oe,
  input  wire logic        i_ack_n,
  input  wire logic        i_ack_oe,
  input  wire logic        i_data_oe,
  input  wire logic [7:0]  i_data,
  output logic             o_cs_n,
  output logic             o_rd_n,
  output logic             o_wr_n,
  output logic             o_as_n,
  output logic [15:0]      o_addr,
  output logic [7:0]       o_data
);
  int n_early = 0;

  // --------------------------------------------------------------
  // one bus cycle
  // --------------------------------------------------------------
  // hold 0 waits for the answer, else the strobe stays hold clocks
  task automatic xfer(input logic rd, input logic [15:0] a,
      input logic [7:0] wd, input int hold,
      output logic [7:0] rdat, output int lowc);
    logic ans;
    lowc = 0;
    @(posedge i_ref_clk);
    o_cs_n <= 1'b0;
    o_addr <= a;
    o_data <= wd;                     // data from strobe start
    o_as_n <= ~i_style;
    o_rd_n <= i_style ? rd : ~rd;     // 68k: high means read
    o_wr_n <= i_style | rd;
    for (int i = 0; i < 40; i++) begin
      @(posedge i_ref_clk);
      ans = i_style ? (i_ack_oe && !i_ack_n) : (i_wait_oe && i_wait_n);
      if (hold == 0 && ans) break;    // strobe kept to answer
      if (hold != 0 && i == hold - 1) break; // min width
      if (hold == 0 && i_data_oe && i_style) n_early++;
      lowc++;                         // clocks still waiting for answer
    end
    rdat = i_data_oe ? i_data : ~i_data; // undriven bus reads as junk
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
    o_wr_n <= 1'b1;
    o_as_n <= 1'b1;
    o_addr <= ~a;
    o_data <= ~wd;  // released bus no longer shows the old value
  endtask

  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_as_n = 1'b1;
    o_addr = 16'h0000;
    o_data = 8'h00;
  end
endmodule

`default_nettype wire

/* File: dv/host_bus_cycle_timing_tb.sv */
// testbench of the host port timing core
`timescale 1ns/100ps
`default_nettype none

module host_bus_cycle_timing_tb;
  logic clk, rst_n, direct, hs, cs_n, rd_n, wr_n, as_n, q_we, q_mem;
  logic [1:0] style;
  logic [15:0] addr, q_idx, idx;
  logic [7:0] hdata, rdata, odata, q_wd, wd;
  logic data_oe, wait_n, wait_oe, ack_n, ack_oe, req, we, mem;
  int n_fail = 0, total_checks = 0, nreq = 0;

  hbt_port i_hbt_port (.i_ref_clk(clk), .i_arst_n(rst_n),
    .i_bus_style(style), .i_direct(direct), .i_handshake(hs),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr_strobe_n(as_n),
    .i_addr(addr), .i_data(hdata), .o_data(odata), .o_data_oe(data_oe),
    .o_wait_n(wait_n), .o_wait_oe(wait_oe), .o_transfer_ack_n(ack_n),
    .o_transfer_ack_oe(ack_oe), .o_req(req), .o_req_we(we),
    .o_req_mem(mem), .o_req_index(idx), .o_req_wdata(wd), .i_rdata(rdata));

  hbt_host_model i_hbt_host_model (.i_ref_clk(clk), .i_style(style[0]),
    .i_wait_n(wait_n), .i_wait_oe(wait_oe), .i_ack_n(ack_n),
    .i_ack_oe(ack_oe), .i_data_oe(data_oe), .i_data(odata), .o_cs_n(cs_n),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_as_n(as_n), .o_addr(addr),
    .o_data(hdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // capture each internal request pulse
  always @(posedge clk) begin
    if (req === 1'b1) begin
      nreq <= nreq + 1;
      q_we <= we;
      q_mem <= mem;
      q_wd <= wd;
      q_idx <= idx;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_max(input int got, input int lim);
    total_checks++;
    if (got > lim) begin
      n_fail++;
      $display("FAIL t=%0t count %h max %h", $time, got, lim);
    end
  endtask

  // common tail: pins released, one request, target decode
  task automatic tail(input int n0, input logic w, input logic m,
      input logic [15:0] a);
    @(posedge clk); // request capture settles one edge after the pulse
    chk({13'h0, wait_oe, ack_oe, data_oe}, 16'h0);
    chk(16'(nreq - n0), 16'h1);
    chk({15'h0, q_we}, {15'h0, w});
    if (direct) begin
      chk({15'h0, q_mem}, {15'h0, m});
      chk(q_idx, m ? a - hbt_pkg::MEM_BASE : a);
    end else begin
      chk({15'h0, q_mem}, {15'h0, a[0]});
      chk(q_idx, 16'h0000);
    end
  endtask

  task automatic t_read(input logic [15:0] a, input logic [7:0] d,
      input int lim, input logic m);
    logic [7:0] r;
    int lc, n0;
    n0 = nreq;
    @(posedge clk);
    rdata <= d;
    i_hbt_host_model.xfer(1'b1, a, 8'h00, hs ? 0 : lim + 2, r, lc);
    chk({8'h0, r}, {8'h0, d});
    if (hs) chk_max(lc, lim);
    repeat (2) @(posedge clk);
    tail(n0, 1'b0, m, a);
  endtask

  // gap of 6 in direct and 4 in indirect between writes
  task automatic t_write(input logic [15:0] a, input logic [7:0] d,
      input logic m);
    logic [7:0] r;
    int lc, n0;
    n0 = nreq;
    i_hbt_host_model.xfer(1'b0, a, d, hs ? 0 : 4, r, lc);
    if (hs) chk_max(lc, 2);
    repeat (direct ? 4 : 2) @(posedge clk);
    tail(n0, 1'b1, m, a);
    chk({8'h0, q_wd}, {8'h0, d});
  endtask

  task automatic give_verdict;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end

  initial begin
    rst_n = 1'b0;
    style = 2'h0;
    direct = 1'b1;
    hs = 1'b1;
    rdata = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // all eight mixes of generic/68k, direct/indirect, handshake or not
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      style <= {1'b0, m[2]};
      direct <= ~m[0];
      hs <= ~m[1];
      @(posedge clk);
      t_read(16'h0012, 8'h5a, 2, 1'b0);
      t_read(16'h8003, 8'ha5, 7, 1'b1);
      t_write(16'h0021, 8'h3c, 1'b0);
      t_write(16'h8010, 8'hc3, 1'b1);
    end
    chk(16'(i_hbt_host_model.n_early), 16'h0);
    give_verdict();
  end
endmodule

`default_nettype wire

/* File: logic/hbt_decode.sv */
// address decoder: register or display memory target of a host cycle
`timescale 1ns/100ps
`default_nettype none

module hbt_decode (
  input  wire logic        i_direct,
  input  wire logic [15:0] i_addr,
  output logic             o_is_mem,
  output logic [15:0]      o_index
);

  // ---------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------
  // indirect uses bit 0 as port select, direct decodes sixteen bits [RL16]
  always_comb begin
    if (i_direct) begin
      o_is_mem = (i_addr >= hbt_pkg::MEM_BASE);
      o_index  = o_is_mem ? (i_addr - hbt_pkg::MEM_BASE) : i_addr;
    end else begin
      o_is_mem = i_addr[0];
      o_index  = 16'h0000;
    end
  end

endmodule

`default_nettype wire

/* File: logic/hbt_pkg.sv */
// package: timing constants, encodings and states of the host port block
package hbt_pkg;

  // ---------------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;   // sys_clk_period at 50 MHz
  // hold/ack limits are stated in whole system clocks
  localparam int unsigned HOLD_REG_TS   = 2;    // register access, mem write
  localparam int unsigned HOLD_MEM_TS   = 7;    // display memory read
  // no-handshake data valid limits: n clocks plus a margin in ns
  localparam int unsigned NOHS_REG_TS   = 2;
  localparam int unsigned NOHS_MEM_TS   = 6;
  localparam int unsigned NOHS_EXTRA_NS = 19;
  // longest time rounds down: the 19 ns margin adds no cycle at 20 ns
  localparam int unsigned NOHS_REG_CYC  =
    NOHS_REG_TS + NOHS_EXTRA_NS / CLK_PERIOD_NS;
  localparam int unsigned NOHS_MEM_CYC  =
    NOHS_MEM_TS + NOHS_EXTRA_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // bus styles and address map
  // ---------------------------------------------------------------------
  localparam logic [15:0] MEM_BASE      = 16'h8000; // direct: memory window
  localparam logic [2:0]  CNT_RESET     = 3'h0;

  typedef enum logic [1:0] {
    HBT_GENERIC = 2'h0,
    HBT_STROBE_AS = 2'h1
  } hbt_bus_t;

  typedef enum logic {
    HBT_REG = 1'b0,
    HBT_MEM = 1'b1
  } hbt_target_t;

  typedef enum {
    HBT_IDLE,
    HBT_BUSY,
    HBT_DONE
  } hbt_state_t;

endpackage

/* File: logic/hbt_port.sv */
// host port timing core: strobe tracking, hold/ack timing and read data
`timescale 1ns/100ps
`default_nettype none

// Contract
// RL1: handshake generic bus holds wait low at most 2, or 7 clocks.
// RL2: host keeps strobe asserted until wait has risen.
// RL3: read data is valid when wait is released high.
// RL4: after strobe ends, wait output goes to high impedance.
// RL5: host presents write data one clock before write strobe ends.
// RL6: indirect mode inactive gaps of 2 or 1 clocks between strobes.
// RL7: direct handshake mode needs four clocks between writes.
// RL8: indirect no-handshake cycles last 4, or 7 clocks, minimum.
// RL9: no-handshake strobes active 3, or 6 clocks, minimum.
// RL10: direct no-handshake cycles 5 or 8 clocks, gaps 2 clocks.
// RL11: no-handshake read data within 2, or 6 clocks, of strobe.
// RL12: transfer_ack_n driven after addr_strobe_n falls, released after rise.
// RL13: ack within 2 clocks, or 7 for memory reads, data valid.
// RL14: host keeps data strobe until hold or ack has gone low.
// RL15: read data appears on the bus no earlier than ack falls.
// RL16: indirect uses one address bit, direct a sixteen-bit decode.
module hbt_port #(
  parameter int unsigned MEM_LAT = hbt_pkg::NOHS_MEM_TS - 1, // 6 clock limit
  parameter int unsigned REG_LAT = hbt_pkg::HOLD_REG_TS - 1
) (
  input  wire logic        i_ref_clk,
  input  wire logic        i_arst_n,
  // configuration straps
  input  wire logic [1:0]  i_bus_style,
  input  wire logic        i_direct,
  input  wire logic        i_handshake,
  // host pins
  input  wire logic        i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic        i_addr_strobe_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_data,
  output logic [7:0]       o_data,
  output logic             o_data_oe,
  output logic             o_wait_n,
  output logic             o_wait_oe,
  output logic             o_transfer_ack_n,
  output logic             o_transfer_ack_oe,
  // internal register / memory side
  output logic             o_req,
  output logic             o_req_we,
  output logic             o_req_mem,
  output logic [15:0]      o_req_index,
  output logic [7:0]       o_req_wdata,
  input  wire logic [7:0]  i_rdata
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  typedef struct packed {
    hbt_pkg::hbt_state_t st;
    logic [2:0]          cnt;
    logic                we;
    logic                mem;
    logic [15:0]         index;
    logic [7:0]          wdata;
    logic [7:0]          rdata;
    logic                data_ok;
    logic                req;
  } hbt_state_s_t;

  hbt_state_s_t cur;
  hbt_state_s_t nxt;

  logic        is_m68;
  logic        rd_act;
  logic        wr_act;
  logic        strobe;
  logic        dec_mem;
  logic [15:0] dec_index;
  logic [2:0]  lat;

  hbt_decode u_decode ( // [RL16]
    .i_direct (i_direct),
    .i_addr   (i_addr),
    .o_is_mem (dec_mem),
    .o_index  (dec_index)
  );

  // 68k style: rd_n carries read/write direction, addr_strobe frames it
  assign is_m68 = (i_bus_style == hbt_pkg::HBT_STROBE_AS);
  assign rd_act = is_m68 ? (!i_addr_strobe_n && i_rd_n)
                         : !i_rd_n;
  assign wr_act = is_m68 ? (!i_addr_strobe_n && !i_rd_n)
                         : !i_wr_n;
  assign strobe = !i_cs_n && (rd_act || wr_act);

  // latency to completion, counted from the first busy clock
  function automatic logic [2:0] lat_of(input logic mem, input logic we);
    lat_of = (mem && !we) ? MEM_LAT[2:0] : REG_LAT[2:0];
  endfunction

  assign lat = lat_of(cur.mem, cur.we);

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  // one access per strobe; done waits for the strobe to end [RL2] [RL14]
  always_comb begin
    nxt     = cur;
    nxt.req = 1'b0;
    case (cur.st)
      hbt_pkg::HBT_IDLE: begin
        nxt.data_ok = 1'b0;
        if (strobe) begin
          nxt.st    = hbt_pkg::HBT_BUSY;
          nxt.cnt   = hbt_pkg::CNT_RESET;
          nxt.we    = wr_act;
          nxt.mem   = dec_mem;
          nxt.index = dec_index;
          nxt.req   = !wr_act; // reads fetch at once
        end
      end
      hbt_pkg::HBT_BUSY: begin
        nxt.cnt = cur.cnt + 3'h1;
        if (cur.cnt + 3'h1 >= lat) begin
          // bounded latency of 2 or 6 clocks [RL1] [RL13] [RL11]
          nxt.st      = hbt_pkg::HBT_DONE;
          nxt.data_ok = !cur.we;
        end
        if (!cur.we && cur.cnt == hbt_pkg::CNT_RESET) begin
          nxt.rdata = i_rdata;
        end
        // a fast host may drop the strobe right after release [RL5]
        if (cur.we && strobe) begin
          nxt.wdata = i_data;
        end
        if (!strobe) begin
          nxt.st = hbt_pkg::HBT_IDLE; // host aborted early
        end
      end
      hbt_pkg::HBT_DONE: begin
        if (strobe) begin
          // sample under the strobe: data need not outlast its end [RL5]
          if (cur.we) begin
            nxt.wdata = i_data;
          end
        end else begin
          nxt.st  = hbt_pkg::HBT_IDLE;
          nxt.req = cur.we; // write issued with the last byte seen
        end
      end
      default: begin
        nxt.st = hbt_pkg::HBT_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cur <= '{st: hbt_pkg::HBT_IDLE, cnt: hbt_pkg::CNT_RESET,
               we: 1'b0, mem: 1'b0, index: 16'h0000,
               wdata: 8'h00, rdata: 8'h00, data_ok: 1'b0, req: 1'b0};
    end else begin
      cur <= nxt;
    end
  end

  // ---------------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------------
  // wait driven low from the strobe itself, floated with it [RL4]
  assign o_wait_oe = !is_m68 && i_handshake && strobe; // [RL1]
  // released high with data already valid [RL3]
  assign o_wait_n  = (cur.st == hbt_pkg::HBT_DONE);
  // ack driven from address strobe fall to its rise [RL12]
  assign o_transfer_ack_oe = is_m68 && i_handshake && !i_addr_strobe_n;
  assign o_transfer_ack_n  = (cur.st != hbt_pkg::HBT_DONE);
  // data driven no earlier than ack or wait release [RL15]
  assign o_data    = cur.rdata;
  assign o_data_oe = rd_act && !i_cs_n && cur.data_ok &&
                     cur.st == hbt_pkg::HBT_DONE;

  assign o_req       = cur.req;
  assign o_req_we    = cur.we;
  assign o_req_mem   = cur.mem;
  assign o_req_index = cur.index;
  assign o_req_wdata = cur.wdata;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  sequence s_start;
    cur.st == hbt_pkg::HBT_IDLE && strobe;
  endsequence

  a_wait_reg_bound: assert property (@(posedge i_ref_clk) // [RL1]
    disable iff (!i_arst_n)
    s_start ##1 (!cur.mem || cur.we) |-> ##[0:1] (cur.st != hbt_pkg::HBT_BUSY))
    else $error("register hold too long");

  a_wait_mem_bound: assert property (@(posedge i_ref_clk) // [RL13]
    disable iff (!i_arst_n)
    s_start ##1 (cur.mem && !cur.we) |-> ##[0:6]
      (cur.st != hbt_pkg::HBT_BUSY))
    else $error("memory read hold too long");

  a_data_at_rel: assert property (@(posedge i_ref_clk) // [RL3]
    disable iff (!i_arst_n)
    (o_wait_oe && o_wait_n && !cur.we) |-> cur.data_ok)
    else $error("wait released without data");

  a_wait_release: assert property (@(posedge i_ref_clk) // [RL4]
    disable iff (!i_arst_n)
    !strobe |-> !o_wait_oe)
    else $error("wait driven without strobe");

  a_ack_float: assert property (@(posedge i_ref_clk) // [RL12]
    disable iff (!i_arst_n)
    $rose(i_addr_strobe_n) |-> !o_transfer_ack_oe)
    else $error("ack driven after strobe rise");

  a_data_after_ack: assert property (@(posedge i_ref_clk) // [RL15]
    disable iff (!i_arst_n)
    o_data_oe |-> cur.st == hbt_pkg::HBT_DONE)
    else $error("data driven before ack");

  a_nohs_data: assert property (@(posedge i_ref_clk) // [RL11]
    disable iff (!i_arst_n)
    s_start ##1 !cur.we |-> ##[0:5] (cur.data_ok || !strobe))
    else $error("read data late");

  a_nohs_reg_data: assert property (@(posedge i_ref_clk) // [RL11]
    disable iff (!i_arst_n)
    s_start ##1 (!cur.we && !cur.mem) |-> ##[0:1] (cur.data_ok || !strobe))
    else $error("register read data late");

  a_write_once: assert property (@(posedge i_ref_clk) // [RL5]
    disable iff (!i_arst_n)
    o_req && o_req_we |=> !o_req)
    else $error("write issued twice");

endmodule

`default_nettype wire
